// *** pfta_pkg.sv ***
package pfta_pkg;
    // Program word geometry
    localparam int WORD_W = 24;
    localparam int ROW_WORDS = 32;
    localparam int ROW_BYTES = 96;
    localparam int ROW_IDX_W = 5;
    localparam int LOW_MSB = 15;
    localparam int HIGH_LSB = 16;
    localparam int HIGH_MSB = 23;
    // Flash control register fields
    localparam int CTRL_START_BIT = 15;
    localparam int CTRL_WREN_BIT = 14;
    localparam int CTRL_ERASE_BIT = 6;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_SW_MASK = 16'h7FFF;
    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Reset values and erased pattern
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
    localparam logic [7:0] ADDR_UPPER_RESET = 8'h00;
    localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;
    // Timing: nominal operation length
    localparam longint CLK_PERIOD_PS = 5000;
    localparam longint OP_TIME_PS = 2000000000;
    localparam int OP_CYCLES = int'(OP_TIME_PS / CLK_PERIOD_PS);
    // Sequencer states
    typedef enum logic [1:0] {
        PFTA_IDLE = 2'b00,
        PFTA_ROW = 2'b01,
        PFTA_WAIT = 2'b10
    } pfta_state_t;
endpackage

// *** pfta_table_access.sv ***
`timescale 1ns/100ps
module pfta_table_access #(
    parameter int MEM_LOG2 = 11,
    parameter int OP_CYCLES = pfta_pkg::OP_CYCLES
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_reset, // Synchronous reset, high
    input wire logic i_tbl_valid, // Table operation request
    input wire logic i_tbl_write, // 1 write, 0 read
    input wire logic i_tbl_high, // 1 high part, 0 low word
    input wire logic i_tbl_byte, // 1 byte mode, 0 word mode
    input wire logic [15:0] i_effective_addr, // Effective address
    input wire logic [15:0] i_tbl_wdata, // Table write data
    output logic [15:0] o_tbl_rdata, // Table read data
    output logic o_tbl_done, // Table op taken, pulse
    input wire logic i_page_wr, // Page register write
    input wire logic [7:0] i_page_wdata, // Page register data
    output logic [7:0] o_table_page_reg, // Page register
    input wire logic i_key_wr, // Unlock key write
    input wire logic [7:0] i_key_wdata, // Unlock key data
    input wire logic i_ctrl_wr, // Control register write
    input wire logic [15:0] i_ctrl_wdata, // Control register data
    output logic [15:0] o_flash_control_reg, // Control register
    input wire logic i_addr_low_wr, // Direct address low write
    input wire logic [15:0] i_addr_low_wdata, // Address low data
    input wire logic i_addr_upper_wr, // Direct address upper write
    input wire logic [7:0] i_addr_upper_wdata, // Address upper data
    output logic [15:0] o_flash_addr_low_reg, // Address low register
    output logic [7:0] o_flash_addr_upper_reg, // Address upper register
    output logic o_cpu_stall, // Core stall while busy
    input wire logic i_prog_serial_clock, // Programmer clock pin
    input wire logic i_prog_serial_data, // Data pin input
    output logic o_prog_serial_data, // Data pin output
    output logic o_prog_serial_data_oe, // Data pin drive enable
    input wire logic i_serial_read_mode // Serial shifts latches out
);
    localparam int CNT_W = $clog2(OP_CYCLES + 1);
    localparam int MEM_WORDS = 1 << MEM_LOG2;
    localparam int ROW_W = MEM_LOG2 - pfta_pkg::ROW_IDX_W;

    logic [pfta_pkg::WORD_W-1:0] mem_r [MEM_WORDS];
    logic [pfta_pkg::WORD_W-1:0] latch_r [pfta_pkg::ROW_WORDS];
    logic [7:0] page_r;
    logic [15:0] ctrl_r;
    logic [15:0] addr_low_r;
    logic [7:0] addr_upper_r;
    logic [1:0] key_stage_r;
    pfta_pkg::pfta_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [15:0] rdata_r;
    logic done_r;
    logic busy;
    logic tbl_go;
    logic start_go;
    logic [23:0] tbl_addr;
    logic [MEM_LOG2-1:0] tbl_widx;
    logic [pfta_pkg::ROW_IDX_W-1:0] tbl_lidx;
    logic [ROW_W-1:0] op_row;
    logic [pfta_pkg::ROW_IDX_W-1:0] step;
    logic [pfta_pkg::WORD_W-1:0] rd_word;

    // Serial path signals
    logic [2:0] sck_sync_r;
    logic [1:0] sdi_sync_r;
    logic [4:0] sbit_r;
    logic [pfta_pkg::WORD_W-1:0] sshift_r;
    logic [pfta_pkg::ROW_IDX_W-1:0] sidx_r;
    logic sdo_r;
    logic sck_rise;
    logic sck_fall;
    logic sword_done;

    // Byte lane pick for reads of the addressed word
    function automatic logic [15:0] pfta_read_sel(input logic [23:0] w, input logic hi,
                                                  input logic byte_md, input logic odd);
        logic [15:0] r;
        r = 16'h0000;
        if (!hi && !byte_md) begin
            r = w[pfta_pkg::LOW_MSB:0];
        end else if (!hi) begin
            r = odd ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
        end else if (!byte_md || !odd) begin
            r = {8'h00, w[pfta_pkg::HIGH_MSB:pfta_pkg::HIGH_LSB]};
        end
        return r;
    endfunction

    // Merge of table write data into a latched word
    function automatic logic [23:0] pfta_write_merge(input logic [23:0] w, input logic hi,
                                                     input logic byte_md, input logic odd,
                                                     input logic [15:0] d);
        logic [23:0] r;
        r = w;
        if (!hi && !byte_md) begin
            r[pfta_pkg::LOW_MSB:0] = d;
        end else if (!hi && odd) begin
            r[15:8] = d[7:0];
        end else if (!hi) begin
            r[7:0] = d[7:0];
        end else if (!byte_md || !odd) begin
            r[pfta_pkg::HIGH_MSB:pfta_pkg::HIGH_LSB] = d[7:0];
        end
        return r;
    endfunction

    // Address forming and decode
    assign busy = (state_r != pfta_pkg::PFTA_IDLE);
    assign tbl_go = i_tbl_valid && !busy;
    assign tbl_addr = {page_r, i_effective_addr};
    assign tbl_widx = tbl_addr[MEM_LOG2:1];
    assign tbl_lidx = tbl_addr[pfta_pkg::ROW_IDX_W:1];
    assign rd_word = mem_r[tbl_widx];
    assign op_row = addr_low_r[MEM_LOG2:pfta_pkg::ROW_IDX_W+1];
    assign step = cnt_r[pfta_pkg::ROW_IDX_W-1:0];
    assign start_go = i_ctrl_wr && !busy && i_ctrl_wdata[pfta_pkg::CTRL_START_BIT]
                      && i_ctrl_wdata[pfta_pkg::CTRL_WREN_BIT] && (key_stage_r == 2'h2);

    // Table page register
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            page_r <= pfta_pkg::PAGE_RESET;
        end else if (i_page_wr && !busy) begin
            page_r <= i_page_wdata;
        end
    end

    // Unlock key sequence tracker
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            key_stage_r <= 2'h0;
        end else if (i_key_wr) begin
            if (i_key_wdata == pfta_pkg::KEY_FIRST) begin
                key_stage_r <= 2'h1;
            end else if (i_key_wdata == pfta_pkg::KEY_SECOND && key_stage_r == 2'h1) begin
                key_stage_r <= 2'h2;
            end else begin
                key_stage_r <= 2'h0;
            end
        end else if (i_ctrl_wr || i_tbl_valid || i_page_wr || i_addr_low_wr || i_addr_upper_wr) begin
            key_stage_r <= (key_stage_r == 2'h2 && i_ctrl_wr) ? 2'h0 : (key_stage_r == 2'h1 ? 2'h0 : key_stage_r);
        end
    end

    // Control register with self-clearing start bit
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ctrl_r <= pfta_pkg::CTRL_RESET;
        end else if (state_r == pfta_pkg::PFTA_WAIT && cnt_r == CNT_W'(OP_CYCLES - 1)) begin
            ctrl_r[pfta_pkg::CTRL_START_BIT] <= 1'b0;
        end else if (i_ctrl_wr && !busy) begin
            ctrl_r <= i_ctrl_wdata & pfta_pkg::CTRL_SW_MASK;
            ctrl_r[pfta_pkg::CTRL_START_BIT] <= start_go;
        end
    end

    // Flash address registers
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            addr_low_r <= pfta_pkg::ADDR_LOW_RESET;
            addr_upper_r <= pfta_pkg::ADDR_UPPER_RESET;
        end else if (tbl_go) begin
            addr_low_r <= tbl_addr[15:0];
            addr_upper_r <= tbl_addr[23:16];
        end else if (!busy) begin
            if (i_addr_low_wr) begin
                addr_low_r <= i_addr_low_wdata;
            end
            if (i_addr_upper_wr) begin
                addr_upper_r <= i_addr_upper_wdata;
            end
        end
    end

    // Erase and program sequencer
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_r <= pfta_pkg::PFTA_IDLE;
            cnt_r <= '0;
        end else begin
            unique case (state_r)
                pfta_pkg::PFTA_IDLE: begin
                    cnt_r <= '0;
                    if (start_go) begin
                        state_r <= pfta_pkg::PFTA_ROW;
                    end
                end
                pfta_pkg::PFTA_ROW: begin
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (step == pfta_pkg::ROW_IDX_W'(pfta_pkg::ROW_WORDS - 1)) begin
                        state_r <= pfta_pkg::PFTA_WAIT;
                    end
                end
                pfta_pkg::PFTA_WAIT: begin
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (cnt_r == CNT_W'(OP_CYCLES - 1)) begin
                        state_r <= pfta_pkg::PFTA_IDLE;
                    end
                end
                default: begin
                    state_r <= pfta_pkg::PFTA_IDLE;
                end
            endcase
        end
    end

    // Row array update, one word per cycle
    always_ff @(posedge i_sys_clk) begin
        if (state_r == pfta_pkg::PFTA_ROW) begin
            if (ctrl_r[pfta_pkg::CTRL_ERASE_BIT]) begin
                mem_r[{op_row, step}] <= pfta_pkg::ERASED_WORD;
            end else begin
                mem_r[{op_row, step}] <= latch_r[step];
            end
        end
    end

    // Write latches from table writes or serial words
    always_ff @(posedge i_sys_clk) begin
        if (tbl_go && i_tbl_write) begin
            latch_r[tbl_lidx] <= pfta_write_merge(latch_r[tbl_lidx], i_tbl_high, i_tbl_byte,
                                                  tbl_addr[0], i_tbl_wdata);
        end else if (sword_done && !i_serial_read_mode) begin
            latch_r[sidx_r] <= {sshift_r[pfta_pkg::WORD_W-2:0], sdi_sync_r[1]};
        end
    end

    // Table read data and completion pulse
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rdata_r <= 16'h0000;
            done_r <= 1'b0;
        end else begin
            done_r <= tbl_go;
            if (tbl_go && !i_tbl_write) begin
                rdata_r <= pfta_read_sel(rd_word, i_tbl_high, i_tbl_byte, tbl_addr[0]);
            end
        end
    end

    // Serial pin synchronisers
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sck_sync_r <= 3'h0;
            sdi_sync_r <= 2'h0;
        end else begin
            sck_sync_r <= {sck_sync_r[1:0], i_prog_serial_clock};
            sdi_sync_r <= {sdi_sync_r[0], i_prog_serial_data};
        end
    end

    assign sck_rise = sck_sync_r[1] && !sck_sync_r[2];
    assign sck_fall = !sck_sync_r[1] && sck_sync_r[2];
    assign sword_done = sck_rise && (sbit_r == 5'(pfta_pkg::WORD_W - 1));

    // Serial shifter, MSB first, 24 clocks per word
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sbit_r <= 5'h00;
            sshift_r <= '0;
            sidx_r <= '0;
            sdo_r <= 1'b0;
        end else if (sck_rise) begin
            sshift_r <= (sbit_r == 5'h00 && i_serial_read_mode) ? latch_r[sidx_r] << 1
                        : {sshift_r[pfta_pkg::WORD_W-2:0], sdi_sync_r[1]};
            sbit_r <= sword_done ? 5'h00 : sbit_r + 5'h01;
            if (sword_done) begin
                sidx_r <= sidx_r + pfta_pkg::ROW_IDX_W'(1);
            end
        end else if (i_serial_read_mode && (sck_fall || sbit_r == 5'h00)) begin
            // Word MSB stands before the first clock, later bits change on falling edges
            sdo_r <= (sbit_r == 5'h00) ? latch_r[sidx_r][pfta_pkg::WORD_W-1] : sshift_r[pfta_pkg::WORD_W-1];
        end
    end

    assign o_tbl_rdata = rdata_r;
    assign o_tbl_done = done_r;
    assign o_table_page_reg = page_r;
    assign o_flash_control_reg = ctrl_r;
    assign o_flash_addr_low_reg = addr_low_r;
    assign o_flash_addr_upper_reg = addr_upper_r;
    assign o_cpu_stall = busy;
    assign o_prog_serial_data = sdo_r;
    assign o_prog_serial_data_oe = i_serial_read_mode;
endmodule

// *** pfta_table_access_monitor.sv ***
`timescale 1ns/100ps
module pfta_table_access_monitor #(
    parameter int OP_CYCLES = pfta_pkg::OP_CYCLES
) (
    input wire logic i_sys_clk, // Clock
    input wire logic i_reset, // Reset
    input wire logic i_tbl_valid, // Op request
    input wire logic i_tbl_write, // Write op
    input wire logic i_tbl_high, // High part
    input wire logic i_tbl_byte, // Byte mode
    input wire logic [15:0] i_effective_addr, // Address
    input wire logic [15:0] o_tbl_rdata, // Read data
    input wire logic o_tbl_done, // Op done
    input wire logic [7:0] o_table_page_reg, // Page
    input wire logic i_ctrl_wr, // Ctrl write
    input wire logic [15:0] i_ctrl_wdata, // Ctrl data
    input wire logic [15:0] o_flash_control_reg, // Ctrl reg
    input wire logic [15:0] o_flash_addr_low_reg, // Addr low
    input wire logic [7:0] o_flash_addr_upper_reg, // Addr upper
    input wire logic o_cpu_stall, // Stall
    input wire logic o_prog_serial_data_oe, // Data enable
    input wire logic i_serial_read_mode // Read mode
);
    logic [31:0] stall_cnt_r;
    // Counts stall cycles of one operation
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || !o_cpu_stall) stall_cnt_r <= 32'h0;
        else stall_cnt_r <= stall_cnt_r + 32'h1;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // Table op handshake and addressing
    take_done_a: assert property (i_tbl_valid && !o_cpu_stall |=> o_tbl_done) else $error("no done");
    done_cause_a: assert property (o_tbl_done |-> $past(i_tbl_valid && !o_cpu_stall)) else $error("stray done");
    addr_catch_a: assert property (i_tbl_valid && !o_cpu_stall |=>
        {o_flash_addr_upper_reg, o_flash_addr_low_reg} == $past({o_table_page_reg, i_effective_addr}))
        else $error("bad address capture");
    high_odd_a: assert property (i_tbl_valid && !o_cpu_stall && !i_tbl_write && i_tbl_high && i_tbl_byte
        && i_effective_addr[0] |=> o_tbl_rdata == 16'h0000) else $error("high odd byte not zero");
    // Operation start, length and clear
    stall_len_a: assert property ($fell(o_cpu_stall) |-> stall_cnt_r == OP_CYCLES) else $error("bad length");
    busy_bit_a: assert property (o_cpu_stall |-> o_flash_control_reg[15]) else $error("start bit low");
    self_clear_a: assert property ($fell(o_cpu_stall) |-> !o_flash_control_reg[15]) else $error("no clear");
    start_cause_a: assert property ($rose(o_cpu_stall) |-> $past(i_ctrl_wr && i_ctrl_wdata[15])) else $error("stray op");
    oe_mode_a: assert property (o_prog_serial_data_oe == i_serial_read_mode) else $error("bad enable");
    cover property ($fell(o_cpu_stall));
    cover property (i_tbl_valid && i_tbl_write);
    cover property (i_tbl_valid && i_tbl_high && i_tbl_byte);
endmodule
bind pfta_table_access pfta_table_access_monitor #(.OP_CYCLES(OP_CYCLES)) i_pfta_table_access_monitor (
    .i_sys_clk, .i_reset, .i_tbl_valid, .i_tbl_write, .i_tbl_high, .i_tbl_byte, .i_effective_addr,
    .o_tbl_rdata, .o_tbl_done, .o_table_page_reg, .i_ctrl_wr, .i_ctrl_wdata, .o_flash_control_reg,
    .o_flash_addr_low_reg, .o_flash_addr_upper_reg, .o_cpu_stall, .o_prog_serial_data_oe, .i_serial_read_mode);

// *** pfta_core_model.sv ***
`timescale 1ns/100ps
module pfta_core_model (
    input wire logic i_sys_clk, // Clock
    input wire logic i_cpu_stall, // Core held
    input wire logic i_tbl_done, // Op taken
    input wire logic [15:0] i_tbl_rdata, // Read data
    output logic o_tbl_valid, // Op request
    output logic [2:0] o_tbl_mode, // Write, high, byte
    output logic [15:0] o_addr, // Effective address
    output logic [15:0] o_wdata // Write data
);
    // Idle core at time zero
    initial begin
        o_tbl_valid = 1'h0;
        o_tbl_mode = 3'h0;
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
    end
    // One table op, one cycle of valid, answer one cycle after
    task automatic op(input logic [2:0] m, input logic [15:0] a, d, output logic [15:0] q, output logic ok);
        @(posedge i_sys_clk);
        while (i_cpu_stall === 1'h1) @(posedge i_sys_clk);
        o_tbl_valid <= 1'h1;
        o_tbl_mode <= m;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_sys_clk);
        o_tbl_valid <= 1'h0;
        o_addr <= ~a;
        #1 ok = i_tbl_done;
        q = i_tbl_rdata;
    endtask
endmodule

// *** program_flash_table_access_tb.sv ***
`timescale 1ns/100ps
module program_flash_table_access_tb;
    localparam int OPC = 40;
    logic clk = 1'h0, reset = 1'h1, rmode = 1'h0, valid, done, stall, oe;
    logic sck = 1'h0, sdi = 1'h0, sdo, sq;
    logic [23:0] sword;
    logic [3:0] st = 4'h0;
    logic [2:0] md;
    logic [15:0] wd = 16'h0000, ea, td, rd, ctrl, alow;
    logic [7:0] page, aup;
    int failures = 0, total_checks = 0, n;
    logic [7:0] byte_exp [4] = '{8'h00, 8'hA0, 8'h10, 8'h00};
    // 200 MHz clock
    always #2.5 clk = ~clk;
    pfta_table_access #(.OP_CYCLES(OPC)) i_pfta_table_access (.i_sys_clk(clk), .i_reset(reset),
        .i_tbl_valid(valid), .i_tbl_write(md[2]), .i_tbl_high(md[1]), .i_tbl_byte(md[0]), .i_effective_addr(ea),
        .i_tbl_wdata(td), .o_tbl_rdata(rd), .o_tbl_done(done), .i_page_wr(st[0]), .i_page_wdata(wd[7:0]),
        .o_table_page_reg(page), .i_key_wr(st[1]), .i_key_wdata(wd[7:0]), .i_ctrl_wr(st[2]), .i_ctrl_wdata(wd),
        .o_flash_control_reg(ctrl), .i_addr_low_wr(st[3]), .i_addr_low_wdata(wd), .i_addr_upper_wr(1'h0),
        .i_addr_upper_wdata(8'h00), .o_flash_addr_low_reg(alow), .o_flash_addr_upper_reg(aup), .o_cpu_stall(stall),
        .i_prog_serial_clock(sck), .i_prog_serial_data(sdi), .o_prog_serial_data(sdo),
        .o_prog_serial_data_oe(oe), .i_serial_read_mode(rmode));
    pfta_core_model i_pfta_core_model (.i_sys_clk(clk), .i_cpu_stall(stall), .i_tbl_done(done),
        .i_tbl_rdata(rd), .o_tbl_valid(valid), .o_tbl_mode(md), .o_addr(ea), .o_wdata(td));
    task automatic chk(input string nm, input logic [23:0] s, e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Register write: 0 page, 1 key, 2 ctrl, 3 addr low
    task automatic wr(input int k, input logic [15:0] d);
        @(posedge clk);
        st <= 4'(1 << k);
        wd <= d;
        @(posedge clk);
        st <= 4'h0;
    endtask
    task automatic t(input logic [2:0] m, input logic [15:0] a, d, e, input string nm);
        logic [15:0] q;
        logic ok;
        i_pfta_core_model.op(m, a, d, q, ok);
        chk({nm, " done"}, 24'(ok), 24'h000001);
        if (!m[2]) chk(nm, 24'(q), 24'(e));
    endtask
    task automatic go(input logic [15:0] c);
        wr(1, 16'h0055);
        wr(1, 16'h00AA);
        wr(2, c);
        #1 chk("stall", 24'(stall), 24'h000001);
        n = 0;
        while (stall === 1'h1 && n < 1000) begin
            @(posedge clk) #1 n++;
        end
        chk("op cycles", 24'(n), 24'(OPC));
        chk("start bit", 24'(ctrl[15]), 24'h000000);
    endtask
    // One programmer clock bit: sample data pin, set data, pulse the clock pin
    task automatic sclk_bit(input logic d, output logic q);
        #1 q = sdo;
        @(posedge clk);
        sdi <= d;
        repeat (4) @(posedge clk);
        sck <= 1'h1;
        repeat (4) @(posedge clk);
        sck <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("ERROR watchdog expected end seen hang");
        conclude();
    end
    // Test sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk) #1 chk("ctrl reset", 24'(ctrl), 24'(pfta_pkg::CTRL_RESET));
        chk("page reset", 24'(page), 24'(pfta_pkg::PAGE_RESET));
        $display("test reset done");
        wr(0, 16'h0001);
        for (int i = 0; i < 32; i++) begin
            t(3'h4, 16'h0040 + 16'(2 * i), 16'hA000 + 16'(i), 16'h0000, "wr low");
            t(3'h6, 16'h0040 + 16'(2 * i), 16'h0010 + 16'(i), 16'h0000, "wr high");
        end
        chk("addr", {aup, alow}, 24'h01007E);
        go(16'hC000);
        for (int i = 0; i < 32; i++) begin
            t(3'h0, 16'h0040 + 16'(2 * i), 16'h0000, 16'hA000 + 16'(i), "rd low");
            t(3'h2, 16'h0040 + 16'(2 * i), 16'h0000, 16'h0010 + 16'(i), "rd high");
        end
        for (int j = 0; j < 4; j++) t({2'(j >> 1), 1'h1}, 16'h0040 + 16'(j & 1), 16'h0000, 16'(byte_exp[j]), "rd byte");
        $display("test program done");
        wr(3, 16'h0040);
        go(16'hC040);
        for (int i = 0; i < 64; i++) t({1'h0, 1'(i & 1), 1'h0}, 16'h0040 + 16'(i & 62), 16'h0000,
            (i & 1) ? 16'h00FF : 16'hFFFF, "erased");
        $display("test erase done");
        wr(2, 16'hC000);
        #1 chk("unkeyed stall", 24'(stall), 24'h000000);
        chk("unkeyed ctrl", 24'(ctrl), 24'h004000);
        $display("test refusal done");
        @(posedge clk);
        rmode <= 1'h1;
        @(posedge clk) #1 chk("data enable", 24'(oe), 24'h000001);
        sword = 24'h10A000;
        for (int b = 23; b >= 0; b--) begin
            sclk_bit(1'h0, sq);
            chk("serial out", 24'(sq), 24'(sword[b]));
        end
        @(posedge clk);
        rmode <= 1'h0;
        @(posedge clk) #1 chk("data enable off", 24'(oe), 24'h000000);
        sword = 24'h5A3C96;
        for (int b = 23; b >= 0; b--) sclk_bit(sword[b], sq);
        go(16'hC000);
        t(3'h0, 16'h0042, 16'h0000, 16'h3C96, "serial low");
        t(3'h2, 16'h0042, 16'h0000, 16'h005A, "serial high");
        $display("test serial done");
        conclude();
    end
endmodule
